//--- include/vrc_pkg.sv
package vrc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] VRC_REF_CTRL_OFS = 12'h90C;
  localparam logic [7:0] VRC_REF_CTRL_RST = 8'h00;
  localparam int VRC_BIT_REF_EN = 7;
  localparam int VRC_BIT_REF_RDY = 6;
  localparam int VRC_BIT_TS_EN = 5;
  localparam int VRC_BIT_TS_RNG = 4;
  localparam int VRC_CMP_GAIN_HI = 3;
  localparam int VRC_CMP_GAIN_LO = 2;
  localparam int VRC_ADC_GAIN_HI = 1;
  localparam int VRC_ADC_GAIN_LO = 0;
  localparam logic [7:0] VRC_WR_MASK = 8'hBF;
  localparam logic VRC_READY_VAL = 1'b1;

  // ****************************************
  // Bus constants
  // ****************************************
  localparam logic [1:0] VRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] VRC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    VRC_GAIN_OFF = 2'b00,
    VRC_GAIN_X1 = 2'b01,
    VRC_GAIN_X2 = 2'b10,
    VRC_GAIN_X4 = 2'b11
  } vrc_gain_t;
endpackage

//--- rtl/vrc_gain_dec.sv
`timescale 1ns/1ns
module vrc_gain_dec (
  // Gain code in
  input wire logic [1:0] code,
  // Decoded buffer controls
  output logic buf_on,
  output logic [2:0] gain_sel
);
  import vrc_pkg::*;

  always_comb begin
    buf_on = 1'b1;
    gain_sel = 3'h0;
    unique case (vrc_gain_t'(code))
      VRC_GAIN_OFF: begin
        buf_on = 1'b0;
      end
      VRC_GAIN_X1: begin
        gain_sel = 3'h1;
      end
      VRC_GAIN_X2: begin
        gain_sel = 3'h2;
      end
      VRC_GAIN_X4: begin
        gain_sel = 3'h4;
      end
    endcase
  end
endmodule

//--- rtl/vrc_ref_ctrl.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// Overview of operation
// - The control register sits at byte 0x90C and every bit except the bit 6 ready flag clears to zero on reset.
// - Bit 7 is a writable enable that turns the fixed reference on or off.
// - Bit 6 is a read-only ready flag that always reads as one on this device.
// - Bit 5 is a writable enable for the temperature sensing circuit.
// - Bit 4 selects the temperature range, one high (four drops), zero low (two drops).
// - Bits 3:2 set the comparator-path buffer gain: off, 1x, 2x or 4x.
// - Bits 1:0 set the converter-path buffer gain: off, 1x, 2x or 4x.
module vrc_ref_ctrl (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog control outputs
  output logic reference_enable,
  output logic temp_sense_enable,
  output logic temp_sense_range,
  output logic [1:0] comparator_ref_gain,
  output logic [1:0] converter_ref_gain,
  output logic cmp_buf_on,
  output logic [2:0] cmp_gain_sel,
  output logic adc_buf_on,
  output logic [2:0] adc_gain_sel
);
  import vrc_pkg::*;

  // ****************************************
  // Write capture state
  // ****************************************
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;

  // ****************************************
  // Control register and write response state
  // ****************************************
  logic [7:0] ctrl_r, ctrl_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;

  // ****************************************
  // Read state
  // ****************************************
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic arready_r, arready_nxt;
  logic [7:0] rd_view;

  // ****************************************
  // Decoded gain state
  // ****************************************
  logic cmp_on_r, cmp_on_nxt;
  logic [2:0] cmp_sel_r, cmp_sel_nxt;
  logic adc_on_r, adc_on_nxt;
  logic [2:0] adc_sel_r, adc_sel_nxt;
  logic cmp_on_d, adc_on_d;
  logic [2:0] cmp_sel_d, adc_sel_d;

  // ****************************************
  // Gain decoders
  // ****************************************
  // comparator gain decode
  vrc_gain_dec u_cmp_dec (
    .code(ctrl_nxt[VRC_CMP_GAIN_HI:VRC_CMP_GAIN_LO]),
    .buf_on(cmp_on_d),
    .gain_sel(cmp_sel_d)
  );
  vrc_gain_dec u_adc_dec (
    .code(ctrl_nxt[VRC_ADC_GAIN_HI:VRC_ADC_GAIN_LO]),
    .buf_on(adc_on_d),
    .gain_sel(adc_sel_d)
  );

  // ****************************************
  // Write capture next state
  // ****************************************
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    // Address and data taken in either order
    if (s_axi_awvalid && awready_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata[7:0];
      wstrb0_nxt = s_axi_wstrb[0];
    end
    // Both halves held, hand over to response
    if (aw_got_r && w_got_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
    end
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
  end

  // ****************************************
  // Control register and write response next state
  // ****************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (aw_got_r && w_got_r) begin
      bvalid_nxt = 1'b1;
      if (awaddr_r[11:2] == VRC_REF_CTRL_OFS[11:2]) begin
        bresp_nxt = VRC_RESP_OKAY;
        if (wstrb0_r) begin
          ctrl_nxt = (wdata_r & VRC_WR_MASK) | (ctrl_r & ~VRC_WR_MASK);
        end
      end else begin
        bresp_nxt = VRC_RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // ****************************************
  // Read next state
  // ****************************************
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    rd_view = ctrl_r;
    rd_view[VRC_BIT_REF_RDY] = VRC_READY_VAL;
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      if (s_axi_araddr[11:2] == VRC_REF_CTRL_OFS[11:2]) begin
        rresp_nxt = VRC_RESP_OKAY;
        rdata_nxt = {24'h000000, rd_view};
      end else begin
        rresp_nxt = VRC_RESP_SLVERR;
        rdata_nxt = 32'h00000000;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  // ****************************************
  // Decoded gain next state
  // ****************************************
  always_comb begin
    cmp_on_nxt = cmp_on_d;
    cmp_sel_nxt = cmp_sel_d;
    adc_on_nxt = adc_on_d;
    adc_sel_nxt = adc_sel_d;
  end

  // ****************************************
  // Write capture registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
    end else if (clk_en) begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
    end
  end

  // ****************************************
  // Control register and write response registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= VRC_REF_CTRL_RST;
      bvalid_r <= 1'b0;
      bresp_r <= VRC_RESP_OKAY;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // ****************************************
  // Read registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= VRC_RESP_OKAY;
      rdata_r <= 32'h00000000;
      arready_r <= 1'b1;
    end else if (clk_en) begin
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      arready_r <= arready_nxt;
    end
  end

  // ****************************************
  // Decoded gain registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_on_r <= 1'b0;
      cmp_sel_r <= 3'h0;
      adc_on_r <= 1'b0;
      adc_sel_r <= 3'h0;
    end else if (clk_en) begin
      cmp_on_r <= cmp_on_nxt;
      cmp_sel_r <= cmp_sel_nxt;
      adc_on_r <= adc_on_nxt;
      adc_sel_r <= adc_sel_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign reference_enable = ctrl_r[VRC_BIT_REF_EN];
  assign temp_sense_enable = ctrl_r[VRC_BIT_TS_EN];
  assign temp_sense_range = ctrl_r[VRC_BIT_TS_RNG];
  assign comparator_ref_gain = ctrl_r[VRC_CMP_GAIN_HI:VRC_CMP_GAIN_LO];
  assign converter_ref_gain = ctrl_r[VRC_ADC_GAIN_HI:VRC_ADC_GAIN_LO];
  assign cmp_buf_on = cmp_on_r;
  assign cmp_gain_sel = cmp_sel_r;
  assign adc_buf_on = adc_on_r;
  assign adc_gain_sel = adc_sel_r;
endmodule

//--- tb/vrc_ref_props.sv
`timescale 1ns/1ns
module vrc_ref_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Analog controls
  input wire logic reference_enable,
  input wire logic temp_sense_enable,
  input wire logic temp_sense_range,
  input wire logic [1:0] comparator_ref_gain,
  input wire logic [1:0] converter_ref_gain,
  input wire logic cmp_buf_on,
  input wire logic [2:0] cmp_gain_sel,
  input wire logic adc_buf_on,
  input wire logic [2:0] adc_gain_sel
);
  import vrc_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);
  function automatic logic [3:0] dec(input logic [1:0] c);
    return c == 2'h0 ? 4'h0 : {1'h1, 3'h1 << (c - 2'h1)};
  endfunction
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence b_two_later;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_reset_clears: assert property (disable iff (1'h0) !aresetn |=> !s_axi_bvalid &&
    !s_axi_rvalid && !reference_enable && !temp_sense_enable && comparator_ref_gain == 2'h0)
    else $error("state not cleared by reset");
  a_wr_resp_time: assert property (wr_both |=> b_two_later)
    else $error("write response late or early");
  a_wr_busy_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rd_busy_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_rd_resp_time: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ready_reads_one: assert property (s_axi_rvalid && s_axi_rresp == VRC_RESP_OKAY |-> s_axi_rdata[6])
    else $error("ready flag read as zero");
  a_rd_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_rd_matches_out: assert property ($rose(s_axi_rvalid) && !s_axi_bvalid && s_axi_rresp == 2'h0
    |-> s_axi_rdata[7:0] == {reference_enable, 1'h1, temp_sense_enable, temp_sense_range,
    comparator_ref_gain, converter_ref_gain})
    else $error("read data differs from outputs");
  a_cmp_decode: assert property ({cmp_buf_on, cmp_gain_sel} == dec(comparator_ref_gain))
    else $error("comparator gain decode wrong");
  a_adc_decode: assert property ({adc_buf_on, adc_gain_sel} == dec(converter_ref_gain))
    else $error("converter gain decode wrong");
  a_unmapped_rd: assert property (rd_take ##0 s_axi_araddr[11:2] != VRC_REF_CTRL_OFS[11:2]
    |=> s_axi_rresp == VRC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind vrc_ref_ctrl vrc_ref_props vrc_ref_props_inst (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .reference_enable(reference_enable), .temp_sense_enable(temp_sense_enable),
  .temp_sense_range(temp_sense_range), .comparator_ref_gain(comparator_ref_gain),
  .converter_ref_gain(converter_ref_gain), .cmp_buf_on(cmp_buf_on),
  .cmp_gain_sel(cmp_gain_sel), .adc_buf_on(adc_buf_on), .adc_gain_sel(adc_gain_sel)
);

//--- tb/vrc_ref_ctrl_tb.sv
`timescale 1ns/1ns
module vrc_ref_ctrl_tb;
  import vrc_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, comparator_ref_gain, converter_ref_gain, rs;
  logic reference_enable, temp_sense_enable, temp_sense_range, cmp_buf_on, adc_buf_on;
  logic [2:0] cmp_gain_sel, adc_gain_sel;
  int num_errors = 0, comparisons = 0, cyc = 0;
  vrc_ref_ctrl vrc_ref_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .reference_enable(reference_enable), .temp_sense_enable(temp_sense_enable),
    .temp_sense_range(temp_sense_range), .comparator_ref_gain(comparator_ref_gain),
    .converter_ref_gain(converter_ref_gain), .cmp_buf_on(cmp_buf_on),
    .cmp_gain_sel(cmp_gain_sel), .adc_buf_on(adc_buf_on), .adc_gain_sel(adc_gain_sel)
  );
  always #4 aclk = ~aclk;
  function automatic logic [31:0] exp_rd(input logic [31:0] x);
    return {24'h0, x[7], 1'h1, x[5:0]};
  endfunction
  function automatic logic [31:0] outs();
    return {24'h0, reference_enable, 1'h1, temp_sense_enable, temp_sense_range,
      comparator_ref_gain, converter_ref_gain};
  endfunction
  function automatic logic [31:0] dec(input logic [1:0] c);
    return c == 2'h0 ? 32'h0 : {29'h1, 3'h1 << (c - 2'h1)};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'hAFFDF44B));
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd_reg(VRC_REF_CTRL_OFS);
    chk("reset_read", rd, 32'h40);
    chk("reset_outs", outs(), 32'h40);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom;
      wr_reg(VRC_REF_CTRL_OFS, d, 4'hF);
      chk("wr_resp", 32'(rs), 32'(VRC_RESP_OKAY));
      rd_reg(VRC_REF_CTRL_OFS);
      chk("rd_data", rd, exp_rd(d));
      chk("outs", outs(), exp_rd(d));
      chk("cmp_dec", 32'({cmp_buf_on, cmp_gain_sel}), dec(d[3:2]));
      chk("adc_dec", 32'({adc_buf_on, adc_gain_sel}), dec(d[1:0]));
    end
    wr_reg(VRC_REF_CTRL_OFS, ~d, 4'hE);
    chk("strb_wr", 32'(rs), 32'(VRC_RESP_OKAY));
    wr_reg(12'h910, ~d, 4'hF);
    chk("unmapped_wr", 32'(rs), 32'(VRC_RESP_SLVERR));
    rd_reg(12'h910);
    chk("unmapped_rd", {rd[29:0], rs}, 32'(VRC_RESP_SLVERR));
    chk("unmapped_data", rd, 32'h0);
    rd_reg(VRC_REF_CTRL_OFS);
    chk("kept", rd, exp_rd(d));
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd_reg(VRC_REF_CTRL_OFS);
    chk("rereset_read", rd, 32'h40);
    chk("rereset_outs", outs(), 32'h40);
    chk("rereset_dec", 32'({cmp_buf_on, cmp_gain_sel, adc_buf_on, adc_gain_sel}), 32'h0);
    finish_test();
  end
endmodule
